//--- rtl/dbs_burst_split.sv
// channel configuration check and single-address burst splitter
// assumes an axi4-lite master and a bus that accepts one request at a time
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dbs_burst_split (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic burst_valid,
	input wire logic burst_ready,
	output dbs_pkg::dbs_burst_t burst,
	output logic dual_start,
	output logic irq
);
	import dbs_pkg::*;

	dbs_state_all_t s;
	dbs_state_all_t next_s;
	// ***********************************************
	// helpers
	// ***********************************************
	function automatic logic [31:0] low_mask(input logic [2:0] size);
		case (size)
			SZ_1B: low_mask = 32'h0000_0000;
			SZ_2B: low_mask = 32'h0000_0001;
			SZ_4B: low_mask = 32'h0000_0003;
			default: low_mask = 32'h0000_0007;
		endcase
	endfunction
	function automatic logic [6:0] size_dw(input logic [2:0] size);
		case (size)
			SZ_4DW: size_dw = 7'h04;
			SZ_8DW: size_dw = 7'h08;
			SZ_16DW: size_dw = 7'h10;
			default: size_dw = 7'h20;
		endcase
	endfunction
	function automatic logic [31:0] unit_bytes(input logic [2:0] size);
		case (size)
			SZ_1B: unit_bytes = 32'h0000_0001;
			SZ_2B: unit_bytes = 32'h0000_0002;
			SZ_4B: unit_bytes = 32'h0000_0004;
			default: unit_bytes = 32'h0000_0008;
		endcase
	endfunction
	// negative step expects the low bits complemented
	function automatic logic addr_ok(input logic [31:0] a, input logic [31:0] inc,
		input logic [31:0] m);
		addr_ok = inc[31] ? ((a & m) == m) : ((a & m) == 32'h0);
	endfunction
	function automatic logic step8(input logic [31:0] inc, input logic zero_ok);
		step8 = (inc == 32'h0000_0008) || (inc == 32'hffff_fff8) ||
			(zero_ok && inc == 32'h0);
	endfunction
	function automatic logic cfg_bad(input dbs_regs_t r);
		logic [2:0] sz;
		logic [31:0] m;
		logic fifo;
		logic bad;
		sz = r.ctrl[CTRL_SIZE_LSB +: 3];
		m = low_mask(sz);
		fifo = (sz == SZ_4DW || sz == SZ_8DW) && r.fifo_use;
		bad = 1'b0;
		// swap only for 8 bytes and up
		if (r.ctrl[CTRL_SWAP] && sz < SZ_8B)
			bad = 1'b1;
		if (r.ctrl[CTRL_SINGLE]) begin
			if (!addr_ok(r.src_addr, r.src_inc, m) || (r.count & m) != 32'h0)
				bad = 1'b1;
			if (sz >= SZ_4DW)
				bad = bad || !step8(r.src_inc, 1'b1);
			else if ((r.src_inc & m) != 32'h0)
				bad = 1'b1;
		end else begin
			// no 16 or 32 double-word dual transfers
			if (sz >= SZ_16DW)
				bad = 1'b1;
			// fifo path only for 4 or 8 double words with fifo use
			else if (fifo) begin
				// zero source step accepted, read once per unit
				if (!step8(r.src_inc, 1'b1) || (r.count & m) != 32'h0)
					bad = 1'b1;
				// zero destination step needs burst inhibit
				if (!step8(r.dst_inc, r.ctrl[CTRL_DEST_BURST_INHIBIT]))
					bad = 1'b1;
			end else begin
				// low bits of addresses, steps and count
				if (!addr_ok(r.src_addr, r.src_inc, m) ||
					!addr_ok(r.dst_addr, r.dst_inc, m))
					bad = 1'b1;
				if (((r.src_inc | r.dst_inc | r.count) & m) != 32'h0)
					bad = 1'b1;
			end
		end
		cfg_bad = bad;
	endfunction

	// ***********************************************
	// next state
	// ***********************************************
	logic wr_fire;
	logic [NUM_EVENTS-1:0] ev_set;
	logic [NUM_EVENTS-1:0] ev_clr;
	logic [2:0] sz;
	logic [6:0] sdw;
	logic [4:0] mofs;
	logic [6:0] len;
	logic [6:0] rem_dw;
	logic [31:0] bytes;

	always_comb begin
		next_s = s;
		next_s.dual_start = 1'b0;
		ev_set = '0;
		ev_clr = '0;
		sz = s.regs.ctrl[CTRL_SIZE_LSB +: 3];
		sdw = size_dw(sz);
		// distance measured from the end that the address walks away from
		mofs = s.regs.src_inc[31] ? ~s.addr[7:3] : s.addr[7:3];
		rem_dw = (s.remaining[31:3] > 29'h20) ? 7'h20 : s.remaining[9:3];
		len = 7'h01;
		bytes = 32'h0;
		wr_fire = s.aw_done && s.w_done && !s.bvalid;

		// register writes
		if (awvalid && !s.aw_done) begin
			next_s.aw_done = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (wvalid && !s.w_done) begin
			next_s.w_done = 1'b1;
			next_s.w_data = wdata;
		end
		if (wr_fire) begin
			next_s.aw_done = 1'b0;
			next_s.w_done = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.aw_addr)
				OFF_SRC_ADDR: next_s.regs.src_addr = s.w_data;
				OFF_DST_ADDR: next_s.regs.dst_addr = s.w_data;
				OFF_SRC_INC: next_s.regs.src_inc = s.w_data;
				OFF_DST_INC: next_s.regs.dst_inc = s.w_data;
				OFF_COUNT: next_s.regs.count = s.w_data;
				OFF_CTRL: next_s.regs.ctrl = s.w_data[6:0];
				OFF_MASTER: next_s.regs.fifo_use = s.w_data[0];
				OFF_INT_CLR: ev_clr = s.w_data[NUM_EVENTS-1:0];
				OFF_INT_EN: next_s.regs.int_en = s.w_data[NUM_EVENTS-1:0];
				OFF_STATUS: next_s.bresp = RESP_OKAY;
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;

		// register reads
		if (arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			case (araddr)
				OFF_SRC_ADDR: next_s.rdata = s.regs.src_addr;
				OFF_DST_ADDR: next_s.rdata = s.regs.dst_addr;
				OFF_SRC_INC: next_s.rdata = s.regs.src_inc;
				OFF_DST_INC: next_s.rdata = s.regs.dst_inc;
				OFF_COUNT: next_s.rdata = s.remaining;
				OFF_CTRL: next_s.rdata = {25'h0, s.regs.ctrl};
				OFF_MASTER: next_s.rdata = {31'h0, s.regs.fifo_use};
				OFF_STATUS: next_s.rdata = {29'h0, s.state != ST_IDLE,
					s.regs.status};
				OFF_INT_EN: next_s.rdata = {30'h0, s.regs.int_en};
				OFF_INT_CLR: next_s.rdata = 32'h0;
				default: begin
					next_s.rdata = 32'h0;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end else if (s.rvalid && rready)
			next_s.rvalid = 1'b0;

		// transfer sequencer
		case (s.state)
			ST_IDLE: begin
				if (wr_fire && s.aw_addr == OFF_CTRL && s.w_data[CTRL_START]) begin
					next_s.addr = s.regs.src_addr;
					next_s.remaining = s.regs.count;
					next_s.pend = 6'h0;
					// refuse and flag an illegal setting
					if (cfg_bad(next_s.regs))
						ev_set[ST_CFG_ERR] = 1'b1;
					// dual transfers go to the dual engine
					else if (!s.w_data[CTRL_SINGLE])
						next_s.dual_start = 1'b1;
					else if (s.regs.count == 32'h0)
						ev_set[ST_DONE] = 1'b1;
					else
						next_s.state = ST_CALC;
				end
			end
			ST_CALC: begin
				next_s.req.addr = s.addr;
				next_s.req.size = sz;
				next_s.req.descending = s.regs.src_inc[31];
				next_s.req.lock = 1'b0;
				next_s.pend = 6'h0;
				if (sz >= SZ_4DW) begin
					if (s.pend != 6'h0)
						len = {1'b0, s.pend};
					else if (s.regs.src_inc == 32'h0)
						len = sdw;
					// unaligned start is split by size mode
					else if (!s.regs.ctrl[CTRL_SIZE_MODE])
						// run up to the next aligned address
						len = sdw - ({2'h0, mofs} & (sdw - 7'h01));
					// full size from wherever the address stands
					else begin
						len = sdw;
						// split at the boundary and keep the bus
						if ({2'h0, mofs} + sdw > BOUNDARY_DW) begin
							len = BOUNDARY_DW - {2'h0, mofs};
							if (rem_dw > len) begin
								next_s.req.lock = 1'b1;
								next_s.pend = 6'(sdw - len);
							end
						end
					end
					if ({2'h0, mofs} + len > BOUNDARY_DW)
						len = BOUNDARY_DW - {2'h0, mofs};
					if (len > rem_dw)
						len = rem_dw;
				end
				next_s.req.len = len[5:0];
				next_s.state = ST_SEND;
			end
			ST_SEND: begin
				if (burst_ready) begin
					bytes = (sz >= SZ_4DW) ? {23'h0, s.req.len, 3'h0} :
						unit_bytes(sz);
					if (sz >= SZ_4DW)
						next_s.addr = s.addr + 32'(s.regs.src_inc * {26'h0, s.req.len});
					else
						next_s.addr = s.addr + s.regs.src_inc;
					next_s.remaining = s.remaining - bytes;
					if (s.remaining <= bytes) begin
						next_s.remaining = 32'h0;
						next_s.state = ST_IDLE;
						ev_set[ST_DONE] = 1'b1;
					end else
						next_s.state = ST_CALC;
				end
			end
			default: next_s.state = ST_IDLE;
		endcase

		// sticky events, a set beats a clear in the same cycle
		next_s.regs.status = (s.regs.status & ~ev_clr) | ev_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else
			s <= next_s;
	end

	// ***********************************************
	// outputs
	// ***********************************************
	assign awready = !s.aw_done;
	assign wready = !s.w_done;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = !s.rvalid;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign burst_valid = s.state == ST_SEND;
	assign burst = s.req;
	assign dual_start = s.dual_start;
	assign irq = |(s.regs.status & s.regs.int_en);

	// ***********************************************
	// checks
	// ***********************************************
	logic [6:0] a_sdw;
	assign a_sdw = size_dw(s.req.size);

	boundary_never_crossed_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		burst_valid && burst.size >= SZ_4DW && !burst.descending
		|-> {2'h0, burst.addr[7:3]} + {1'b0, burst.len} <= BOUNDARY_DW)
		else $error("burst crosses a 32 double-word boundary");
	mode0_aligned_full_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		burst_valid && burst.size >= SZ_4DW && !burst.descending &&
		!s.regs.ctrl[CTRL_SIZE_MODE] && s.regs.src_inc != 32'h0 &&
		{1'b0, burst.len} == a_sdw
		|-> ({2'h0, burst.addr[7:3]} & (a_sdw - 7'h01)) == 7'h0)
		else $error("full burst not aligned in normal mode");
	mode0_no_lock_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		burst_valid && !s.regs.ctrl[CTRL_SIZE_MODE] |-> !burst.lock)
		else $error("normal mode issued a locked piece");
	mode1_piece_short_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		burst_valid && burst.lock |-> {1'b0, burst.len} < a_sdw)
		else $error("locked piece is not shorter than size");
	locked_pair_follows_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		burst_valid && burst_ready && burst.lock
		|-> ##2 burst_valid && !burst.lock)
		else $error("second locked piece did not follow");
	request_held_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		burst_valid && !burst_ready |=> burst_valid && $stable(burst))
		else $error("burst request changed before acceptance");
	bad_cfg_flag_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s.state == ST_IDLE && wr_fire && s.aw_addr == OFF_CTRL &&
		s.w_data[CTRL_START] && !s.w_data[CTRL_SINGLE] &&
		s.w_data[2:0] >= SZ_16DW
		|=> s.regs.status[ST_CFG_ERR] && !dual_start ##1 !burst_valid)
		else $error("illegal dual size not refused");
	dest_zero_fifo_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s.state == ST_IDLE && wr_fire && s.aw_addr == OFF_CTRL &&
		s.w_data[CTRL_START] && !s.w_data[CTRL_SINGLE] &&
		!s.w_data[CTRL_DEST_BURST_INHIBIT] && s.regs.fifo_use &&
		s.w_data[2:0] == SZ_4DW && s.regs.dst_inc == 32'h0
		|=> s.regs.status[ST_CFG_ERR])
		else $error("zero destination step accepted without inhibit");
	swap_small_error_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s.state == ST_IDLE && wr_fire && s.aw_addr == OFF_CTRL &&
		s.w_data[CTRL_START] && s.w_data[CTRL_SWAP] && s.w_data[2:0] < SZ_8B
		|=> s.regs.status[ST_CFG_ERR] && !dual_start)
		else $error("byte swap accepted for small size");
endmodule
`default_nettype wire

//--- inc/dbs_pkg.sv
// constants, register map and carrier types of the burst splitter
// assumes a 32-bit byte address space and a 64-bit system bus
`default_nettype none
package dbs_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_SRC_ADDR = 8'h00;
	localparam logic [7:0] OFF_DST_ADDR = 8'h04;
	localparam logic [7:0] OFF_SRC_INC = 8'h08;
	localparam logic [7:0] OFF_DST_INC = 8'h0c;
	localparam logic [7:0] OFF_COUNT = 8'h10;
	localparam logic [7:0] OFF_CTRL = 8'h14;
	localparam logic [7:0] OFF_MASTER = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [7:0] OFF_INT_CLR = 8'h20;
	localparam logic [7:0] OFF_INT_EN = 8'h24;
	// control register fields
	localparam int CTRL_SIZE_LSB = 0;
	localparam int CTRL_SIZE_MODE = 3;
	localparam int CTRL_SINGLE = 4;
	localparam int CTRL_SWAP = 5;
	localparam int CTRL_DEST_BURST_INHIBIT = 6;
	localparam int CTRL_START = 7;
	// status bits: sticky event bits, then live busy bit
	localparam int ST_CFG_ERR = 0;
	localparam int ST_DONE = 1;
	localparam int ST_BUSY = 2;
	localparam int NUM_EVENTS = 2;
	// transfer size codes
	localparam logic [2:0] SZ_1B = 3'h0;
	localparam logic [2:0] SZ_2B = 3'h1;
	localparam logic [2:0] SZ_4B = 3'h2;
	localparam logic [2:0] SZ_8B = 3'h3;
	localparam logic [2:0] SZ_4DW = 3'h4;
	localparam logic [2:0] SZ_8DW = 3'h5;
	localparam logic [2:0] SZ_16DW = 3'h6;
	localparam logic [2:0] SZ_32DW = 3'h7;
	// bursts never cross this many double words
	localparam logic [6:0] BOUNDARY_DW = 7'h20;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_SEND} dbs_state_t;

	// one request to the system bus
	typedef struct packed {
		logic [31:0] addr;
		logic [5:0] len;
		logic [2:0] size;
		logic lock;
		logic descending;
	} dbs_burst_t;

	typedef struct packed {
		logic [31:0] src_addr;
		logic [31:0] dst_addr;
		logic [31:0] src_inc;
		logic [31:0] dst_inc;
		logic [31:0] count;
		logic [6:0] ctrl;
		logic fifo_use;
		logic [NUM_EVENTS-1:0] status;
		logic [NUM_EVENTS-1:0] int_en;
	} dbs_regs_t;

	typedef struct packed {
		dbs_regs_t regs;
		dbs_state_t state;
		logic [31:0] addr;
		logic [31:0] remaining;
		logic [5:0] pend;
		dbs_burst_t req;
		logic aw_done;
		logic w_done;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic dual_start;
	} dbs_state_all_t;
endpackage
`default_nettype wire

//--- bench/dbs_bus_model.sv
// system bus stand-in: takes burst requests, promptly or with stalls
// assumes requests are held stable until taken
`timescale 1ns/10ps
`default_nettype none
module dbs_bus_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	input wire logic burst_valid,
	input wire dbs_pkg::dbs_burst_t burst,
	output logic burst_ready,
	output logic crossed
);
	import dbs_pkg::*;
	logic [6:0] first_dw;
	logic [6:0] last_dw;

	// double-word index inside the 256-byte window
	assign first_dw = {2'h0, burst.addr[7:3]};
	assign last_dw = first_dw + {1'h0, burst.len} - 7'h01;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_ready <= 1'b0;
			crossed <= 1'b0;
		end else begin
			burst_ready <= slow ? 1'($urandom % 2) : 1'b1;
			if (burst_valid && burst_ready && last_dw > 7'h1f)
				crossed <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench of the burst splitter and configuration check
// assumes the bus model drives the system-bus side
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import dbs_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic burst_valid, burst_ready, dual_start, irq, crossed;
	logic [1:0] bresp, rresp, r;
	dbs_burst_t burst;
	dbs_burst_t exp_q[$], got_q[$];
	int mismatches, compares, ds_cnt;

	dbs_burst_split u_dut (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.burst_valid(burst_valid), .burst_ready(burst_ready),
		.burst(burst), .dual_start(dual_start), .irq(irq));
	dbs_bus_model u_bus (.aclk(aclk), .aresetn(aresetn), .slow(slow),
		.burst_valid(burst_valid), .burst(burst),
		.burst_ready(burst_ready), .crossed(crossed));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (burst_valid && burst_ready)
			got_q.push_back(burst);
		if (dual_start === 1'b1)
			ds_cnt++;
	end

	// ****************
	// shared tasks
	// ****************
	task automatic chk(input string n, input logic [63:0] e, g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= v;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic cfg(input logic [31:0] s, dd, si, di, c, input logic f);
		wr(OFF_SRC_ADDR, s);
		wr(OFF_DST_ADDR, dd);
		wr(OFF_SRC_INC, si);
		wr(OFF_DST_INC, di);
		wr(OFF_COUNT, c);
		wr(OFF_MASTER, {31'h0, f});
	endtask

	// expected single-address burst list, ascending addresses
	function automatic void plan(logic [31:0] a, int dw, int sz,
		logic [2:0] code, logic mode);
		int n, b, carry;
		carry = 0;
		while (dw > 0) begin
			// small unit sizes go one unit per request
			if (code < SZ_4DW)
				n = 1;
			else
				n = carry != 0 ? carry : (mode ? sz : sz - int'(a[7:3]) % sz);
			if (n > dw)
				n = dw;
			b = 32 - int'(a[7:3]);
			carry = n > b ? n - b : 0;
			exp_q.push_back('{a, 6'(n > b ? b : n), code, n > b, 1'b0});
			n = n > b ? b : n;
			a += 32'(n * 8);
			dw -= n;
		end
	endfunction

	task automatic single(input logic [31:0] a, input int dw,
		input logic [2:0] code, input logic mode);
		wr(OFF_INT_CLR, 32'h3);
		exp_q.delete();
		got_q.delete();
		plan(a, dw, 4 << (code - 4), code, mode);
		cfg(a, 32'h0, 32'h8, 32'h8, 32'(dw * 8), 1'b0);
		wr(OFF_CTRL, {24'h0, 4'h9, mode, code});
		do rd(OFF_STATUS); while (d[1] !== 1'b1);
		chk("burst count", exp_q.size(), got_q.size());
		foreach (exp_q[i])
			if (i < got_q.size())
				chk("burst", exp_q[i], got_q[i]);
	endtask

	task automatic dual(input logic [7:0] c, input logic [31:0] s, dd, si,
		di, input logic f, e);
		int n0, q0;
		n0 = ds_cnt;
		q0 = got_q.size();
		cfg(s, dd, si, di, 32'h40, f);
		wr(OFF_CTRL, {24'h0, c | 8'h80});
		repeat (3) @(posedge aclk);
		rd(OFF_STATUS);
		chk("config error", e, d[0]);
		chk("dual start", !e, ds_cnt != n0);
		chk("no bursts", q0, got_q.size());
		chk("irq", e, irq);
		wr(OFF_INT_CLR, 32'h3);
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		void'($urandom(32'h587e));
		{aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h0;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a <= 'h28; a += 4) begin
			rd(8'(a));
			chk("reset value", 32'h0, d);
			chk("read resp", a == 'h28 ? RESP_SLVERR : RESP_OKAY, r);
		end
		wr(8'h28, 32'h1);
		chk("write resp", RESP_SLVERR, r);
		wr(OFF_SRC_ADDR, 32'h1234_5678);
		rd(OFF_SRC_ADDR);
		chk("readback", 32'h1234_5678, d);
		wr(OFF_STATUS, 32'h3);
		rd(OFF_STATUS);
		chk("status read only", 32'h0, d);
		single(32'ha8, 12, SZ_4DW, 1'b0);
		chk("masked irq", 1'b0, irq);
		wr(OFF_INT_EN, 32'h2);
		chk("irq on done", 1'b1, irq);
		wr(OFF_INT_CLR, 32'h2);
		chk("irq cleared", 1'b0, irq);
		single(32'ha8, 12, SZ_4DW, 1'b1);
		repeat (10) begin
			slow <= 1'($urandom);
			single({20'h0, 9'($urandom), 3'h0}, 1 + $urandom % 48,
				3'(4 + $urandom % 4), 1'($urandom));
		end
		slow <= 1'b0;
		single(32'h40, 3, SZ_8B, 1'b0);
		wr(OFF_INT_CLR, 32'h3);
		wr(OFF_INT_EN, 32'h3);
		dual(8'h06, 32'h1000, 32'h2000, 32'h8, 32'h8, 1'b1, 1'b1);
		dual(8'h07, 32'h1000, 32'h2000, 32'h8, 32'h8, 1'b1, 1'b1);
		dual(8'h04, 32'h1000, 32'h2000, 32'h8, 32'h0, 1'b1, 1'b1);
		dual(8'h44, 32'h1000, 32'h2000, 32'h8, 32'h0, 1'b1, 1'b0);
		dual(8'h05, 32'h1000, 32'h2107, 32'h0, -32'sd8, 1'b1, 1'b0);
		dual(8'h05, 32'h1000, 32'h2000, 32'h10, 32'h8, 1'b1, 1'b1);
		dual(8'h05, 32'h1000, 32'h2000, 32'h10, 32'h8, 1'b0, 1'b0);
		dual(8'h01, 32'h1001, 32'h2000, 32'h2, 32'h2, 1'b0, 1'b1);
		dual(8'h01, 32'h1002, 32'h2004, 32'h2, 32'h2, 1'b0, 1'b0);
		dual(8'h02, 32'h1000, 32'h2000, 32'h2, 32'h4, 1'b0, 1'b1);
		dual(8'h20, 32'h1000, 32'h2000, 32'h1, 32'h1, 1'b0, 1'b1);
		dual(8'h23, 32'h1000, 32'h2000, 32'h8, 32'h8, 1'b0, 1'b0);
		dual(8'h03, 32'h1007, 32'h2000, -32'sd8, 32'h8, 1'b0, 1'b0);
		dual(8'h03, 32'h1000, 32'h2000, -32'sd8, 32'h8, 1'b0, 1'b1);
		chk("boundary", 1'b0, crossed);
		print_verdict();
	end

	initial begin
		#500000;
		mismatches++;
		print_verdict();
	end
endmodule
`default_nettype wire
